// ===== spmc_pkg.sv
// Notes on behaviour
// - With the pin-direction bit at 0 the data pin is only an input while the data byte moves.
// - With the pin-direction bit at 1 the data pin drives on reads and listens on writes, as instruction bit 7 says.
// - The bit-order bit picks LSB-first or MSB-first for both the instruction and the data byte.
// - Writing 1 to the software reset bit returns the configuration registers to their defaults.
// - The software reset bit clears itself and always reads back as 0.
// - The software reset leaves the mode control register at address 0 untouched.
// - The hardware reset input forces every register, the mode control register included, to its default.
// - The output-sleep bit at 1 switches off the DAC output currents, and at 0 restores them.
// - The power-down bit at 1 shuts down all analog and digital functions except the serial port.
// - The reference-resistor mode bit at its default 0 selects two-resistor mode.
// - The lock status bit reads 1 while the PLL is locked and 0 while it is not.
package spmc_pkg;
	localparam logic [4:0] SPMC_ADDR_MODE = 5'h00;
	localparam logic [7:0] SPMC_MODE_RESET = 8'h00;
	localparam int SPMC_BIT_BIDIR = 7;
	localparam int SPMC_BIT_LSB_FIRST = 6;
	localparam int SPMC_BIT_SOFT_RESET = 5;
	localparam int SPMC_BIT_OUT_SLEEP = 4;
	localparam int SPMC_BIT_POWER_DOWN = 3;
	localparam int SPMC_BIT_REF_MODE = 2;
	localparam int SPMC_BIT_PLL_LOCK = 1;
	localparam int SPMC_INSTR_RW = 7;
	localparam int SPMC_ADDR_MSB = 4;
	localparam logic [3:0] SPMC_CNT_INSTR_LAST = 4'h7;
	localparam logic [3:0] SPMC_CNT_DATA_FIRST = 4'h8;
	localparam logic [3:0] SPMC_CNT_DATA_LAST = 4'hF;
	localparam logic [7:0] SPMC_WRITABLE_MASK = 8'hDC;
endpackage : spmc_pkg

// ===== spmc_sync.sv
`timescale 1ns/10ps
module spmc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb begin
		next_meta = d;
		next_q = meta;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= next_meta;
			q <= next_q;
		end
	end
endmodule : spmc_sync

// ===== spmc_top.sv
`timescale 1ns/10ps
module spmc_top
	import spmc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic spi_sclk,
	input wire logic spi_csb,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	output logic sdo_out,
	input wire logic pll_lock,
	output logic dac_out_sleep,
	output logic dev_power_down,
	output logic reference_resistor_count_mode,
	output logic cfg_defaults_load
);
	// Link-side frame state; a high chip select clears it between frames.
	logic frame_rst;
	logic [3:0] cnt;
	// Extra clock edges after the data byte must not write or toggle again.
	logic frame_done;
	logic next_frame_done;
	logic [7:0] instr;
	logic [7:0] data_sh;
	logic [7:0] mode_reg;
	logic soft_tgl;
	logic pll_lock_s;
	logic [3:0] next_cnt;
	logic [7:0] next_instr;
	logic [7:0] next_data_sh;
	logic [7:0] next_mode_reg;
	logic next_soft_tgl;
	logic [7:0] rx_byte;
	logic [7:0] in_shift;
	logic [7:0] rd_val;

	assign frame_rst = rst | spi_csb;

	function automatic logic [7:0] shift_in(input logic [7:0] v,
		input logic b, input logic lsb_first);
		if (lsb_first) begin
			shift_in = {b, v[7:1]};
		end else begin
			shift_in = {v[6:0], b};
		end
	endfunction : shift_in

	function automatic logic [7:0] read_mux(input logic [4:0] addr,
		input logic [7:0] mode, input logic lock);
		logic [7:0] v;
		v = 8'h00;
		if (addr == SPMC_ADDR_MODE) begin
			v = mode & SPMC_WRITABLE_MASK;
			v[SPMC_BIT_SOFT_RESET] = 1'b0;
			v[SPMC_BIT_PLL_LOCK] = lock;
		end
		read_mux = v;
	endfunction : read_mux

	spmc_sync #(.W(1)) u_lock_sync (
		.clk(spi_sclk),
		.rst(rst),
		.d(pll_lock),
		.q(pll_lock_s)
	);

	always_comb begin
		next_cnt = cnt;
		next_frame_done = frame_done;
		if (cnt != SPMC_CNT_DATA_LAST) begin
			next_cnt = cnt + 4'h1;
		end else begin
			next_frame_done = 1'b1;
		end
	end

	always_ff @(posedge spi_sclk or posedge frame_rst) begin
		if (frame_rst) begin
			cnt <= 4'h0;
			frame_done <= 1'b0;
		end else begin
			cnt <= next_cnt;
			frame_done <= next_frame_done;
		end
	end

	always_comb begin
		in_shift = (cnt <= SPMC_CNT_INSTR_LAST) ? instr : data_sh;
		rx_byte = shift_in(in_shift, sdio_in,
			mode_reg[SPMC_BIT_LSB_FIRST]);
		next_instr = instr;
		next_data_sh = data_sh;
		next_mode_reg = mode_reg;
		next_soft_tgl = soft_tgl;
		if (cnt <= SPMC_CNT_INSTR_LAST) begin
			next_instr = rx_byte;
		end else begin
			next_data_sh = rx_byte;
		end
		// The register changes only on the last data bit, never mid-byte.
		if (cnt == SPMC_CNT_DATA_LAST && !frame_done &&
			!instr[SPMC_INSTR_RW] &&
			instr[SPMC_ADDR_MSB:0] == SPMC_ADDR_MODE) begin
			next_mode_reg = rx_byte & SPMC_WRITABLE_MASK;
			next_mode_reg[SPMC_BIT_SOFT_RESET] = 1'b0;
			if (rx_byte[SPMC_BIT_SOFT_RESET]) begin
				// Mode register keeps the written value, others reload.
				next_soft_tgl = ~soft_tgl;
			end
		end
	end

	always_ff @(posedge spi_sclk or posedge rst) begin
		if (rst) begin
			instr <= 8'h00;
			data_sh <= 8'h00;
			mode_reg <= SPMC_MODE_RESET;
			soft_tgl <= 1'b0;
		end else begin
			instr <= next_instr;
			data_sh <= next_data_sh;
			mode_reg <= next_mode_reg;
			soft_tgl <= next_soft_tgl;
		end
	end

	// Read data launch on the falling edge so the host samples on rising.
	logic [7:0] tx_sh;
	logic tx_on;
	logic [7:0] next_tx_sh;
	logic next_tx_on;
	logic next_sdio_out;
	logic next_sdio_oe;
	logic [7:0] tx_word;
	logic lsb_first;

	assign lsb_first = mode_reg[SPMC_BIT_LSB_FIRST];

	always_comb begin
		rd_val = read_mux(instr[SPMC_ADDR_MSB:0], mode_reg, pll_lock_s);
		next_tx_sh = tx_sh;
		next_tx_on = tx_on;
		tx_word = tx_sh;
		if (cnt == SPMC_CNT_DATA_FIRST && !tx_on) begin
			tx_word = rd_val;
			next_tx_on = instr[SPMC_INSTR_RW];
		end
		if (lsb_first) begin
			next_sdio_out = tx_word[0];
			next_tx_sh = {1'b0, tx_word[7:1]};
		end else begin
			next_sdio_out = tx_word[7];
			next_tx_sh = {tx_word[6:0], 1'b0};
		end
		if (!next_tx_on) begin
			next_sdio_out = 1'b0;
		end
		// Input-only mode: the read byte leaves on the separate output.
		next_sdio_oe = next_tx_on &&
			mode_reg[SPMC_BIT_BIDIR];
	end

	always_ff @(negedge spi_sclk or posedge frame_rst) begin
		if (frame_rst) begin
			tx_sh <= 8'h00;
			tx_on <= 1'b0;
			sdio_out <= 1'b0;
			sdio_oe <= 1'b0;
			sdo_out <= 1'b0;
		end else begin
			tx_sh <= next_tx_sh;
			tx_on <= next_tx_on;
			sdio_out <= next_sdio_out;
			sdio_oe <= next_sdio_oe;
			sdo_out <= next_sdio_out;
		end
	end

	// Control levels and the reset toggle cross into the system clock.
	logic [3:0] ctl_s;
	logic soft_seen;
	logic next_soft_seen;
	logic next_defaults_load;
	logic next_sleep;
	logic next_pd;
	logic next_ref;

	spmc_sync #(.W(4)) u_ctl_sync (
		.clk(clk_sys),
		.rst(rst),
		.d({soft_tgl, mode_reg[SPMC_BIT_OUT_SLEEP],
			mode_reg[SPMC_BIT_POWER_DOWN], mode_reg[SPMC_BIT_REF_MODE]}),
		.q(ctl_s)
	);

	always_comb begin
		next_soft_seen = ctl_s[3];
		next_defaults_load = ctl_s[3] ^ soft_seen;
		next_sleep = ctl_s[2];
		next_pd = ctl_s[1];
		next_ref = ctl_s[0];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			soft_seen <= 1'b0;
			cfg_defaults_load <= 1'b0;
			dac_out_sleep <= 1'b0;
			dev_power_down <= 1'b0;
			reference_resistor_count_mode <= 1'b0;
		end else begin
			soft_seen <= next_soft_seen;
			cfg_defaults_load <= next_defaults_load;
			dac_out_sleep <= next_sleep;
			dev_power_down <= next_pd;
			reference_resistor_count_mode <= next_ref;
		end
	end
endmodule : spmc_top

// ===== spmc_checker.sv
`timescale 1ns/10ps
module spmc_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic spi_sclk,
	input wire logic spi_csb,
	input wire logic sdio_out,
	input wire logic sdio_oe,
	input wire logic sdo_out,
	input wire logic dac_out_sleep,
	input wire logic dev_power_down,
	input wire logic reference_resistor_count_mode,
	input wire logic cfg_defaults_load
);
	logic [4:0] n;
	logic [4:0] next_n;
	always_comb next_n = (n == 5'h10) ? n : n + 5'h01;
	always_ff @(posedge spi_sclk or posedge spi_csb) begin
		if (spi_csb) n <= 5'h00;
		else n <= next_n;
	end
	sequence s_idle;
		spi_csb [*8];
	endsequence
	a_oe_instr: assert property (
		@(negedge spi_sclk) disable iff (rst || spi_csb)
		n < 5'h09 |-> !sdio_oe) else $error("early drive");
	a_oe_idle: assert property (
		@(posedge clk_sys) disable iff (rst)
		spi_csb |-> !sdio_oe) else $error("drive outside frame");
	a_out_zero: assert property (
		@(posedge clk_sys) disable iff (rst)
		spi_csb |-> !sdio_out && !sdo_out) else $error("data outside frame");
	a_sdo_copy: assert property (
		@(posedge clk_sys) disable iff (rst)
		sdio_oe |-> sdio_out == sdo_out) else $error("pins differ");
	a_pulse_single: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(cfg_defaults_load) |=> !cfg_defaults_load)
		else $error("long pulse");
	a_idle_nopulse: assert property (
		@(posedge clk_sys) disable iff (rst)
		s_idle |-> !cfg_defaults_load) else $error("pulse when idle");
	a_idle_quiet: assert property (
		@(posedge clk_sys) disable iff (rst)
		s_idle |-> $stable({dac_out_sleep, dev_power_down,
		reference_resistor_count_mode})) else $error("mode moved when idle");
	a_reset_outs: assert property (@(posedge clk_sys) rst |->
		!dac_out_sleep && !dev_power_down && !reference_resistor_count_mode
		&& !cfg_defaults_load) else $error("output set in reset");
endmodule : spmc_checker
bind spmc_top spmc_checker chk_i (.clk_sys(clk_sys), .rst(rst),
	.spi_sclk(spi_sclk), .spi_csb(spi_csb), .sdio_out(sdio_out),
	.sdio_oe(sdio_oe), .sdo_out(sdo_out), .dac_out_sleep(dac_out_sleep),
	.dev_power_down(dev_power_down), .cfg_defaults_load(cfg_defaults_load),
	.reference_resistor_count_mode(reference_resistor_count_mode));

// ===== spmc_host.sv
`timescale 1ns/10ps
module spmc_host (
	output logic spi_sclk,
	output logic spi_csb,
	output logic hd,
	input wire logic sdio_out,
	input wire logic sdio_oe,
	input wire logic sdo_out
);
	// Set when the device drove the shared data pin during the last frame.
	logic oe_any;
	initial begin
		spi_sclk = 1'b0;
		spi_csb = 1'b1;
		hd = 1'b0;
	end
	// Host shifts both bytes in the agreed order.
	task automatic xfer(input logic [7:0] ins, input logic [7:0] dat,
		input logic lsb, input int nb, output logic [7:0] rd);
		int k;
		rd = 8'h00;
		oe_any = 1'b0;
		spi_csb = 1'b0;
		for (int i = 0; i < nb; i++) begin
			k = lsb ? i % 8 : 7 - i % 8;
			// A released line toggles so a stale bit never passes.
			if (i < 8) hd = ins[k];
			else if (ins[7]) hd = ~hd;
			else hd = dat[k];
			#6 spi_sclk = 1'b1;
			if (i > 7) rd[k] = sdio_oe ? sdio_out : sdo_out;
			oe_any = oe_any | sdio_oe;
			#6 spi_sclk = 1'b0;
		end
		#6 spi_csb = 1'b1;
		hd = ~hd;
		#12;
	endtask : xfer
endmodule : spmc_host

// ===== serial_port_mode_control_bench.sv
`timescale 1ns/10ps
module serial_port_mode_control_bench;
	logic clk = 1'b0, lk = 1'b0, md = 1'b0, rst;
	logic sclk, csb, hd, di, dout, oe, so, slp, pd, rm, dl;
	logic [7:0] rd;
	int error_cnt = 0, checked = 0, i;
	logic [18:0] rows [7] = '{{8'h10, 8'h10, 3'h4}, {8'h08, 8'h08, 3'h2},
		{8'h04, 8'h04, 3'h1}, {8'h23, 8'h00, 3'h0}, {8'hDC, 8'hDC, 3'h7},
		{8'h80, 8'h80, 3'h0}, {8'h00, 8'h00, 3'h0}};
	assign di = oe ? dout : hd;
	spmc_top uut (.clk_sys(clk), .rst(rst), .spi_sclk(sclk), .spi_csb(csb),
		.sdio_in(di), .sdio_out(dout), .sdio_oe(oe), .sdo_out(so),
		.pll_lock(lk), .dac_out_sleep(slp), .dev_power_down(pd),
		.reference_resistor_count_mode(rm), .cfg_defaults_load(dl));
	spmc_host h (.spi_sclk(sclk), .spi_csb(csb), .hd(hd), .sdio_out(dout),
		.sdio_oe(oe), .sdo_out(so));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic give_verdict;
		if (error_cnt == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict
	initial begin
		forever #4 clk = ~clk;
	end
	initial begin
		#100000 error_cnt++;
		give_verdict;
	end
	initial begin
		// An edge on reset is needed; an initialiser alone clears nothing.
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[j]) begin
			h.xfer(8'h00, rows[j][18:11], md, 16, rd);
			md = rows[j][17];
			h.xfer(8'h80, 8'h00, md, 16, rd);
			chk(rd, rows[j][10:3]);
			chk({7'h00, h.oe_any}, {7'h00, rows[j][18]});
			repeat (6) @(posedge clk);
			chk({5'h00, slp, pd, rm}, {5'h00, rows[j][2:0]});
		end
		h.xfer(8'h00, 8'h30, md, 16, rd);
		for (i = 0; i < 20 && dl !== 1'b1; i++) @(negedge clk);
		chk({7'h00, dl}, 8'h01);
		if (i == 20) give_verdict;
		h.xfer(8'h01, 8'hFF, md, 16, rd);
		h.xfer(8'h00, 8'hFF, md, 12, rd);
		h.xfer(8'h80, 8'h00, md, 16, rd);
		chk(rd, 8'h10);
		@(posedge clk) lk <= 1'b1;
		h.xfer(8'h80, 8'h00, md, 16, rd);
		chk(rd, 8'h12);
		@(posedge clk) rst <= 1'b1;
		lk <= 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		h.xfer(8'h80, 8'h00, md, 16, rd);
		chk(rd, 8'h00);
		chk({5'h00, slp, pd, rm}, 8'h00);
		give_verdict;
	end
endmodule : serial_port_mode_control_bench
